// >>> src/lfs_pkg.sv
// constants and types shared by the led fault supervisor
package lfs_pkg;
  localparam int unsigned N_SINK = 6;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned LOW_CLEAR_MS = 16;
  localparam int unsigned LOW_CLEAR_CYC = LOW_CLEAR_MS * (CLK_HZ / 1_000);
  localparam int unsigned UV_FALL_US = 50;
  localparam int unsigned UV_FALL_CYC = UV_FALL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned IN_OC_SHUT_NS = 3_000;
  localparam int unsigned IN_OC_SHUT_CYC = IN_OC_SHUT_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 24;

  typedef logic [CNT_W-1:0] lfs_cnt_t;

  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_WAIT  = 5'h02,
    ST_SHORT = 5'h04,
    ST_RUN   = 5'h08,
    ST_LATCH = 5'h10
  } lfs_state_t;

  typedef struct packed {
    logic lim1;
    logic lim2;
    logic in_oc;
  } lfs_trip_t;

  typedef struct packed {
    logic boost;
    logic disc;
    logic [N_SINK-1:0] sinks;
  } lfs_drive_t;

  localparam lfs_drive_t DRIVE_RST = '{boost: 1'b0, disc: 1'b0, sinks: 6'h00};
  localparam lfs_cnt_t CNT_RST = 24'h000000;
endpackage

// >>> src/lfs_supervisor.sv
// fault supervision core of the boost led driver
//
// Behaviour
// R01: primary trip ends on-time, no fault flag
// R02: secondary trip shuts down and latches off
// R03: secondary trip drops all switches, flags fault
// R04: secondary latch clears after 16 ms low
// R05: input overcurrent shuts down within 3 us, latches
// R06: input overcurrent drops disconnect, boost and sinks
// R07: input overcurrent latch clears after 16 ms low
// R08: enable on rise, disable after 50 us fall
// R09: led ground short halts soft-start, flags fault
// R10: short check at startup only, auto resume
// R11: fault flag is open-drain, active low
// R12: low-time counter restarts when input rises
`timescale 1ns/1ps
module lfs_supervisor
  import lfs_pkg::*;
#(
  parameter int unsigned LOW_CLEAR_CYCLES = LOW_CLEAR_CYC,
  parameter int unsigned UV_FALL_CYCLES = UV_FALL_CYC
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic dim,
  input wire logic sw_cycle_start,
  input wire logic on_time_end,
  input wire lfs_trip_t trip,
  input wire logic uv_rise,
  input wire logic uv_fall,
  input wire logic [N_SINK-1:0] led_gnd_short,
  output lfs_drive_t drive,
  output logic soft_start_run,
  output logic fault_o,
  output logic fault_oe
);
  localparam int shut_max_c = IN_OC_SHUT_CYC;

  lfs_state_t st_q;
  lfs_state_t st_d;
  lfs_drive_t drv_q;
  lfs_drive_t drv_d;
  lfs_cnt_t low_cnt_q;
  lfs_cnt_t low_cnt_d;
  lfs_cnt_t uv_cnt_q;
  lfs_cnt_t uv_cnt_d;
  logic vin_ok_q;
  logic vin_ok_d;
  logic on_q;
  logic on_d;
  logic fault_q;

  wire any_short = |led_gnd_short;
  wire active = (st_q != ST_OFF) && (st_q != ST_LATCH);
  wire hard_trip = trip.lim2 || trip.in_oc;
  wire low_seen = !en || !dim;
  wire clear_done = (low_cnt_q == lfs_cnt_t'(LOW_CLEAR_CYCLES));
  wire uv_done = (uv_cnt_q == lfs_cnt_t'(UV_FALL_CYCLES));

  // low-time counter on enable or dimming, restarts once both are high
  assign low_cnt_d = !low_seen ? CNT_RST : // R12
    clear_done ? low_cnt_q : low_cnt_q + lfs_cnt_t'(1);

  // undervoltage filter, only a continuous fall counts
  assign uv_cnt_d = !uv_fall ? CNT_RST : uv_done ? uv_cnt_q : uv_cnt_q + lfs_cnt_t'(1);
  assign vin_ok_d = uv_rise ? 1'b1 : (uv_fall && uv_done) ? 1'b0 : vin_ok_q; // R08

  // boost on-time latch, primary trip cuts it at once
  assign on_d = trip.lim1 ? 1'b0 : // R01
    sw_cycle_start ? 1'b1 : on_time_end ? 1'b0 : on_q;

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_OFF:
      begin
        if (vin_ok_q && en)
          st_d = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (!en)
          st_d = ST_OFF;
        else if (dim)
          st_d = any_short ? ST_SHORT : ST_RUN; // R09 R10
      end
      ST_SHORT:
      begin
        if (!en)
          st_d = ST_OFF;
        else if (!any_short)
          st_d = ST_RUN; // R10
      end
      ST_RUN:
      begin
        if (!en)
          st_d = ST_OFF;
      end
      ST_LATCH:
      begin
        if (clear_done)
          st_d = ST_OFF; // R04 R07
      end
    endcase
    if (active && hard_trip)
      st_d = ST_LATCH; // R02 R05
    if (!vin_ok_d)
      st_d = ST_OFF;
  end

  // switch drive follows the next state so a trip acts on the next edge
  assign drv_d.boost = (st_d == ST_RUN) && on_d && !hard_trip; // R01 R03 R06
  assign drv_d.disc = ((st_d == ST_RUN) || (st_d == ST_SHORT) || (st_d == ST_WAIT))
    && !hard_trip; // R03 R06 R09
  assign drv_d.sinks = ((st_d == ST_RUN) && dim && !hard_trip) ? {N_SINK{1'b1}}
    : {N_SINK{1'b0}}; // R03 R09

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= ST_OFF;
      drv_q <= DRIVE_RST;
      low_cnt_q <= CNT_RST;
      uv_cnt_q <= CNT_RST;
      vin_ok_q <= 1'b0;
      on_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      drv_q <= drv_d;
      low_cnt_q <= low_cnt_d;
      uv_cnt_q <= uv_cnt_d;
      vin_ok_q <= vin_ok_d;
      on_q <= on_d;
      fault_q <= (st_d == ST_LATCH) || (st_d == ST_SHORT); // R03 R05 R09
    end
  end

  assign drive = drv_q;
  assign soft_start_run = (st_q == ST_RUN);
  assign fault_o = 1'b0; // R11
  assign fault_oe = fault_q; // R11

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  lim1_trunc_a: assert property (trip.lim1 |=> !drive.boost) // R01
    else $error("boost still on after primary trip");

  lim1_nolatch_a: assert property ((st_q == ST_RUN) && trip.lim1 && !hard_trip && en // R01
    && vin_ok_q && !uv_fall |=> (st_q == ST_RUN) && !fault_oe)
    else $error("primary trip changed state or flag");

  boost_run_a: assert property (drive.boost |-> soft_start_run) // R01
    else $error("boost gate on outside run state");

  lim2_off_a: assert property (active && trip.lim2 && vin_ok_q && !uv_fall // R02
    |=> (st_q == ST_LATCH) && (drive == DRIVE_RST) && fault_oe)
    else $error("secondary trip did not latch off");

  off_refuse_a: assert property ((st_q == ST_OFF) && hard_trip |=> !fault_oe) // R02
    else $error("trip in off state raised the flag");

  lim2_hold_a: assert property ((st_q == ST_LATCH) |-> !drive.disc && !drive.boost // R03
    && (drive.sinks == 6'h00) && fault_oe)
    else $error("latched state drives a switch or hides the flag");

  sink_dim_a: assert property (!dim |=> (drive.sinks == 6'h00)) // R03
    else $error("led sinks on while dimming input low");

  latch_hold_a: assert property ((st_q == ST_LATCH) && !clear_done && vin_ok_d // R04
    |=> (st_q == ST_LATCH))
    else $error("latch left before low time elapsed");

  clear_exit_a: assert property ((st_q == ST_LATCH) && clear_done && vin_ok_d // R04
    |=> (st_q == ST_OFF) && !fault_oe)
    else $error("latch not released after low time");

  latch_clear_a: assert property ((st_q == ST_LATCH) && $past(st_q == ST_LATCH) // R07
    && $past(!low_seen) |-> (low_cnt_q == 0))
    else $error("low counter ran with both inputs high");

  inoc_shut_a: assert property (active && trip.in_oc && vin_ok_q // R05
    |-> ##[1:shut_max_c] ((drive == DRIVE_RST) && fault_oe))
    else $error("input overcurrent shutdown too slow");

  inoc_disc_a: assert property (trip.in_oc |=> !drive.disc && !drive.boost // R06
    && (drive.sinks == 6'h00))
    else $error("input overcurrent left a switch on");

  uv_filter_a: assert property ($fell(vin_ok_q) |-> $past(uv_done) && $past(uv_fall) // R08
    && $past(uv_fall, 2))
    else $error("undervoltage disable without full filter time");

  uv_glitch_a: assert property (!uv_fall |=> (uv_cnt_q == 0)) // R08
    else $error("undervoltage filter not restarted");

  rise_enable_a: assert property (uv_rise |=> vin_ok_q) // R08
    else $error("input not enabled after rising level");

  short_entry_a: assert property ((st_q == ST_WAIT) && dim && any_short && en // R09
    && !hard_trip && vin_ok_d |=> (st_q == ST_SHORT) && fault_oe)
    else $error("led ground short at startup not caught");

  short_halt_a: assert property ((st_q == ST_SHORT) |-> drive.disc && !drive.boost // R09
    && (drive.sinks == 6'h00) && fault_oe && !soft_start_run)
    else $error("led ground short not halting soft-start");

  short_resume_a: assert property ((st_q == ST_SHORT) && !any_short && en && !hard_trip // R10
    && vin_ok_d |=> (st_q == ST_RUN))
    else $error("soft-start did not resume after short removed");

  run_nocheck_a: assert property ((st_q == ST_RUN) && any_short && en && !hard_trip // R10
    && vin_ok_d |=> (st_q == ST_RUN))
    else $error("ground short check acted after startup");

  wait_dark_a: assert property ((st_q == ST_WAIT) |-> !drive.boost // R10
    && (drive.sinks == 6'h00) && !fault_oe && !soft_start_run)
    else $error("waiting state drives boost, sinks or flag");

  run_disc_a: assert property (soft_start_run |-> drive.disc && !fault_oe) // R10
    else $error("run state without disconnect or with flag");

  flag_drive_a: assert property (fault_oe == $past(st_d == ST_LATCH || st_d == ST_SHORT) // R11
    && !fault_o)
    else $error("fault pin not open-drain low on fault");

  oe_fault_a: assert property (fault_oe |-> (st_q == ST_LATCH) || (st_q == ST_SHORT)) // R11
    else $error("fault pin pulled low without a fault");

  cnt_restart_a: assert property (en && dim |=> (low_cnt_q == 0)) // R12
    else $error("low-time counter not restarted");

  low_step_a: assert property (low_seen && !clear_done // R12
    |=> (low_cnt_q == $past(low_cnt_q) + lfs_cnt_t'(1)))
    else $error("low-time counter did not advance");
endmodule

// >>> tb/lfs_fault_pullup.sv
// fault line with pull-up driven by a single open-drain flag driver
`timescale 1ns/1ps
module lfs_fault_pullup (
  input wire logic fault_o,
  input wire logic fault_oe,
  output logic fault_line
);
  assign fault_line = fault_oe ? fault_o : 1'b1;
endmodule

// >>> tb/tb_lfs_supervisor.sv
// testbench for the led fault supervisor
`timescale 1ns/1ps
module tb_lfs_supervisor;
  import lfs_pkg::*;
  logic clk = 0, rstn = 0, en = 0, dim = 0, sw = 0, ote = 0, uvr = 0, uvf = 0;
  lfs_trip_t trip = 3'h0;
  logic [5:0] sh = 6'h00;
  lfs_drive_t drive;
  logic ssr, fo, foe, fl;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  wire [9:0] o = {drive, fl, ssr};
  always #5 clk = ~clk;
  lfs_supervisor #(.LOW_CLEAR_CYCLES(20), .UV_FALL_CYCLES(8)) u_dut (.clk(clk),
    .rstn(rstn), .en(en), .dim(dim), .sw_cycle_start(sw), .on_time_end(ote),
    .trip(trip), .uv_rise(uvr), .uv_fall(uvf), .led_gnd_short(sh),
    .drive(drive), .soft_start_run(ssr), .fault_o(fo), .fault_oe(foe));
  lfs_fault_pullup u_pull (.fault_o(fo), .fault_oe(foe), .fault_line(fl));
  task final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [9:0] exp);
    n_checks++;
    if (o !== exp)
    begin
      error_cnt++;
      $display("Error %s exp %h got %h", nm, exp, o);
    end
  endtask
  task go;
    @(posedge clk) {uvr, en, dim} <= 3'h7;
    w(5);
    chk("run", 10'h1ff);
  endtask
  task t_lim1;
    go();
    @(posedge clk) sw <= 1;
    @(posedge clk) sw <= 0;
    w(1);
    chk("boost on", 10'h3ff);
    @(posedge clk) trip <= 3'h4;
    @(posedge clk) trip <= 3'h0;
    #1 chk("lim1 cut", 10'h1ff);
    @(posedge clk) sw <= 1;
    @(posedge clk) sw <= 0;
    w(1);
    chk("next cycle", 10'h3ff);
    @(posedge clk) ote <= 1;
    @(posedge clk) ote <= 0;
    #1 chk("on end", 10'h1ff);
  endtask
  task t_lim2;
    @(posedge clk) trip <= 3'h2;
    @(posedge clk) trip <= 3'h0;
    #1 chk("lim2 off", 10'h000);
    @(posedge clk) en <= 0;
    w(15);
    @(posedge clk) en <= 1;
    w(2);
    chk("still latched", 10'h000);
    @(posedge clk) en <= 0;
    w(15);
    chk("low 15", 10'h000);
    w(12);
    chk("cleared", 10'h002);
  endtask
  task t_inoc;
    go();
    @(posedge clk) trip <= 3'h1;
    @(posedge clk) trip <= 3'h0;
    #1 chk("in oc off", 10'h000);
    @(posedge clk) dim <= 0;
    w(15);
    chk("oc latched", 10'h000);
    w(12);
    chk("oc cleared", 10'h102);
  endtask
  task t_short;
    @(posedge clk) {en, dim} <= 2'h2;
    w(4);
    chk("wait", 10'h102);
    @(posedge clk) {sh, dim} <= 7'h09;
    w(2);
    chk("short", 10'h100);
    @(posedge clk) sh <= 6'h00;
    w(2);
    chk("resume", 10'h1ff);
    @(posedge clk) sh <= 6'h3f;
    w(3);
    chk("no check", 10'h1ff);
    @(posedge clk) sh <= 6'h00;
  endtask
  task t_uv;
    @(posedge clk) {uvr, uvf} <= 2'h1;
    w(6);
    @(posedge clk) uvf <= 0;
    w(2);
    chk("glitch", 10'h1ff);
    @(posedge clk) uvf <= 1;
    w(12);
    chk("uv off", 10'h002);
    @(posedge clk) {uvf, trip} <= 4'h1;
    @(posedge clk) trip <= 3'h0;
    #1 chk("off trip", 10'h002);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      final_report();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    t_lim1();
    t_lim2();
    t_inoc();
    t_short();
    t_uv();
    go();
    final_report();
  end
endmodule
